// File: dosc_regs.sv
// Drive option status and control register bank
`default_nettype none
// Function
// [RL1] Healthy traffic: report messages counted over the last second.
// [RL2] Ring active but no messages received: report zero.
// [RL3] Network reconfiguration detected: report minus one.
// [RL4] Interface configuration failed: report minus two.
// [RL5] This node forced a reconfiguration: report minus three.
// [RL6] Lockout and drive enabled: reject download; trip 70 if global trips.
// [RL7] Profile error trips with 81 when select is 0, none at 1.
// [RL8] Sync status 0 without master request or when another is master.
// [RL9] Sync status 1 as master, 3 if master with bad frequency.
// [RL10] Sequence control codes: 0 run, 1 stop, 2 pause, 3 step.
// [RL11] Pass-through set: local freeze input drives internal freeze line.
// [RL12] Freeze event on input rise at polarity 0, fall at 1.
// [RL13] Without local input, capture on drive pulse edge by polarity.
// [RL14] Task priority bits are independent, each software settable.
// [RL15] Synchronise local freeze input before edge detection.
module dosc_regs
    import dosc_pkg::*;
#(
    parameter longint SECOND_LEN = SECOND_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        ring_active,
    input  wire logic        net_msg_rx,
    input  wire logic        net_reconfig_seen,
    input  wire logic        net_init_fail,
    input  wire logic        self_forced_reconfig,
    input  wire logic        drive_enabled,
    input  wire logic        download_req,
    input  wire logic        global_trip_en,
    input  wire logic        motion_profile_core_err,
    input  wire logic        sync_master_req,
    input  wire logic        other_is_master,
    input  wire logic        sync_freq_ok,
    input  wire logic        has_local_freeze,
    input  wire logic        local_freeze_input,
    input  wire logic        drive_freeze_pulse,
    output logic             download_reject,
    output logic             trip_req,
    output logic      [7:0]  trip_code,
    output logic             freeze_line,
    output logic             freeze_event,
    output logic      [1:0]  seq_mode,
    output logic      [7:0]  task_prio,
    output logic             irq
);
    typedef struct packed {
        logic [15:0] rdata;
        logic [15:0] net_health;
        logic [15:0] msg_cnt;
        logic [31:0] sec_cnt;
        logic        dl_lockout;
        logic        prof_trip_sel;
        logic [1:0]  seq_ctrl;
        logic        frz_pass;
        logic        frz_pol;
        logic [7:0]  prio;
        logic [IRQ_BITS-1:0] irq_stat;
        logic [IRQ_BITS-1:0] irq_mask;
        logic        dl_rej;
        logic        trip;
        logic [7:0]  tcode;
        logic        frz_line;
        logic        frz_evt;
        logic        sync0;
        logic        sync1;
        logic        frz_prev;
        logic        pulse_prev;
        logic        net_reconfig_seen_prev;
    } dosc_state_t;

    dosc_state_t st;
    dosc_state_t next_st;
    logic        frz_src;
    logic        frz_edge;
    logic [1:0]  sync_stat;
    logic [IRQ_BITS-1:0] ev;
    logic [15:0] msg_sum;

    // Message of the closing cycle still belongs to that window
    assign msg_sum = (net_msg_rx && st.msg_cnt != NET_MSG_MAX)
        ? st.msg_cnt + 16'h0001 : st.msg_cnt;

    // Sync status is live state, not a stored setting
    always_comb begin
        if (!sync_master_req || other_is_master) begin
            sync_stat = SYNC_NONE;                             // [RL8]
        end else if (!sync_freq_ok) begin
            sync_stat = SYNC_MASTER_BAD;                       // [RL9]
        end else begin
            sync_stat = SYNC_MASTER;                           // [RL9]
        end
    end

    // Only the second stage is looked at by the edge logic
    assign frz_src = has_local_freeze ? st.sync1 : drive_freeze_pulse;
    assign frz_edge = st.frz_pol
        ? (st.frz_prev && !frz_src)                            // [RL12] [RL13]
        : (!st.frz_prev && frz_src);                           // [RL12] [RL13]

    always_comb begin
        next_st = st;
        next_st.sync0 = local_freeze_input;                    // [RL15]
        next_st.sync1 = st.sync0;                              // [RL15]
        next_st.frz_prev = frz_src;
        next_st.frz_evt = frz_edge;
        next_st.pulse_prev = drive_freeze_pulse;
        next_st.net_reconfig_seen_prev = net_reconfig_seen;
        // Line follows the synchronised level, gated by pass-through
        next_st.frz_line = st.frz_pass && st.sync1;            // [RL11]

        // Download lockout and trip selection
        next_st.dl_rej = download_req && st.dl_lockout
            && drive_enabled;                                  // [RL6]
        next_st.trip = 1'b0;
        if (download_req && st.dl_lockout && drive_enabled
            && global_trip_en) begin
            next_st.trip  = 1'b1;                              // [RL6]
            next_st.tcode = TRIP_DOWNLOAD;
        end else if (motion_profile_core_err && !st.prof_trip_sel) begin
            next_st.trip  = 1'b1;                              // [RL7]
            next_st.tcode = TRIP_PROFILE;
        end

        // Message rate over a one-second window, saturating count
        next_st.msg_cnt = msg_sum;
        if (st.sec_cnt == 32'(SECOND_LEN - 1)) begin
            next_st.sec_cnt = 32'h0;
            next_st.msg_cnt = 16'h0;
        end else begin
            next_st.sec_cnt = st.sec_cnt + 32'h1;
        end
        // Faults take priority over the rate figure
        if (net_init_fail) begin
            next_st.net_health = NET_INIT_ERR;                 // [RL4]
        end else if (self_forced_reconfig) begin
            next_st.net_health = NET_SELF_NET_RECONFIG_SEEN;               // [RL5]
        end else if (net_reconfig_seen) begin
            next_st.net_health = NET_RECONFIG;                 // [RL3]
        end else if (!ring_active) begin
            next_st.net_health = st.net_health;
        end else if (st.sec_cnt == 32'(SECOND_LEN - 1)) begin
            next_st.net_health = msg_sum;                      // [RL1] [RL2]
        end else if (st.net_health[15]) begin
            next_st.net_health = NET_NO_DATA;                  // [RL2]
        end

        ev = '0;
        ev[IRQ_FREEZE]    = frz_edge;
        ev[IRQ_TRIP]      = next_st.trip;
        ev[IRQ_DL_REJECT] = next_st.dl_rej;
        ev[IRQ_RECONFIG]  = net_reconfig_seen && !st.net_reconfig_seen_prev;

        // Register port; read data valid the cycle after the strobe
        next_st.rdata = 16'h0;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_DL_LOCKOUT:  next_st.dl_lockout    = reg_wdata[0];
                ADDR_PROF_TRIP:   next_st.prof_trip_sel = reg_wdata[0];
                ADDR_SEQ_CTRL:    next_st.seq_ctrl      = reg_wdata[1:0]; // [RL10]
                ADDR_FRZ_PASS:    next_st.frz_pass      = reg_wdata[0];
                ADDR_FRZ_POL:     next_st.frz_pol       = reg_wdata[0];
                ADDR_TASK_PRIO:   next_st.prio          = reg_wdata[7:0]; // [RL14]
                ADDR_IRQ_MASK:    next_st.irq_mask = reg_wdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_NET_HEALTH:  next_st.rdata = st.net_health;
                ADDR_DL_LOCKOUT:  next_st.rdata = {15'h0, st.dl_lockout};
                ADDR_PROF_TRIP:   next_st.rdata = {15'h0, st.prof_trip_sel};
                ADDR_SYNC_STATUS: next_st.rdata = {14'h0, sync_stat};
                ADDR_SEQ_CTRL:    next_st.rdata = {14'h0, st.seq_ctrl};
                ADDR_FRZ_PASS:    next_st.rdata = {15'h0, st.frz_pass};
                ADDR_FRZ_POL:     next_st.rdata = {15'h0, st.frz_pol};
                ADDR_TASK_PRIO:   next_st.rdata = {8'h0, st.prio};
                ADDR_IRQ_STATUS:  next_st.rdata = {12'h0, st.irq_stat};
                ADDR_IRQ_MASK:    next_st.rdata = {12'h0, st.irq_mask};
                ADDR_TRIP_CODE:   next_st.rdata = {8'h0, st.tcode};
                default:          next_st.rdata = 16'h0;
            endcase
        end
        // Read clears, but a same-cycle event survives
        if (reg_rd && reg_addr == ADDR_IRQ_STATUS) begin
            next_st.irq_stat = ev;
        end else begin
            next_st.irq_stat = st.irq_stat | ev;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata       = st.rdata;
    assign download_reject = st.dl_rej;
    assign trip_req        = st.trip;
    assign trip_code       = st.tcode;
    assign freeze_line     = st.frz_line;
    assign freeze_event    = st.frz_evt;
    assign seq_mode        = st.seq_ctrl;
    assign task_prio       = st.prio;
    assign irq             = |(st.irq_stat & st.irq_mask);

    a_lockout_reject: assert property ( // [RL6]
        @(posedge clk_sys) disable iff (rst)
        (download_req && st.dl_lockout && drive_enabled) |=> download_reject)
        else $error("download not rejected");

    a_lockout_trip: assert property ( // [RL6]
        @(posedge clk_sys) disable iff (rst)
        (download_req && st.dl_lockout && drive_enabled && global_trip_en)
        |=> (trip_req && trip_code == TRIP_DOWNLOAD))
        else $error("download trip missing");

    a_profile_trip: assert property ( // [RL7]
        @(posedge clk_sys) disable iff (rst)
        (motion_profile_core_err && st.prof_trip_sel && !download_req)
        |=> !trip_req)
        else $error("profile trip not suppressed");

    a_sync_other: assert property ( // [RL8]
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == ADDR_SYNC_STATUS && other_is_master)
        |=> reg_rdata == 16'h0)
        else $error("sync status not zero");

    a_sync_bad: assert property ( // [RL9]
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == ADDR_SYNC_STATUS && sync_master_req
         && !other_is_master && !sync_freq_ok) |=> reg_rdata == 16'h3)
        else $error("sync status not three");

    // Two synchroniser stages plus the output flop
    a_freeze_pass: assert property ( // [RL11]
        @(posedge clk_sys) disable iff (rst)
        (st.frz_pass && local_freeze_input)[*3] |=> freeze_line)
        else $error("freeze line not passed");

    a_freeze_rise: assert property ( // [RL12]
        @(posedge clk_sys) disable iff (rst)
        (has_local_freeze && !st.frz_pol && $rose(st.sync1))
        |=> freeze_event)
        else $error("rising freeze missed");

    a_net_init: assert property ( // [RL4]
        @(posedge clk_sys) disable iff (rst)
        net_init_fail |=> st.net_health == NET_INIT_ERR)
        else $error("init error not reported");

    a_net_self: assert property ( // [RL5]
        @(posedge clk_sys) disable iff (rst)
        (self_forced_reconfig && !net_init_fail)
        |=> st.net_health == NET_SELF_NET_RECONFIG_SEEN)
        else $error("self reconfig not reported");

    a_dl_quiet: assert property ( // [RL6]
        @(posedge clk_sys) disable iff (rst)
        !(download_req && st.dl_lockout && drive_enabled)
        |=> !download_reject)
        else $error("download rejected without cause");

    a_dl_no_global: assert property ( // [RL6]
        @(posedge clk_sys) disable iff (rst)
        (download_req && st.dl_lockout && drive_enabled
         && !global_trip_en && !motion_profile_core_err) |=> !trip_req)
        else $error("download trip without global enable");

    a_profile_fire: assert property ( // [RL7]
        @(posedge clk_sys) disable iff (rst)
        (motion_profile_core_err && !st.prof_trip_sel && !download_req)
        |=> (trip_req && trip_code == TRIP_PROFILE))
        else $error("profile trip missing");

    a_sync_none: assert property ( // [RL8]
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == ADDR_SYNC_STATUS && !sync_master_req)
        |=> reg_rdata == 16'h0)
        else $error("sync status not zero without request");

    a_sync_master: assert property ( // [RL9]
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == ADDR_SYNC_STATUS && sync_master_req
         && !other_is_master && sync_freq_ok) |=> reg_rdata == 16'h1)
        else $error("sync status not one");

    a_seq_write: assert property ( // [RL10]
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == ADDR_SEQ_CTRL)
        |=> seq_mode == $past(reg_wdata[1:0]))
        else $error("sequence code not taken");

    a_prio_write: assert property ( // [RL14]
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == ADDR_TASK_PRIO)
        |=> task_prio == $past(reg_wdata[7:0]))
        else $error("priority bits not taken");

    a_prio_hold: assert property ( // [RL14]
        @(posedge clk_sys) disable iff (rst)
        !(reg_wr && reg_addr == ADDR_TASK_PRIO) |=> $stable(task_prio))
        else $error("priority bits changed unasked");

    a_freeze_off: assert property ( // [RL11]
        @(posedge clk_sys) disable iff (rst)
        !st.frz_pass |=> !freeze_line)
        else $error("freeze line driven while off");

    a_freeze_fall: assert property ( // [RL12]
        @(posedge clk_sys) disable iff (rst)
        (has_local_freeze && st.frz_pol && $fell(st.sync1))
        |=> freeze_event)
        else $error("falling freeze missed");

    // A steady input must never yield a second event
    a_freeze_quiet: assert property ( // [RL15]
        @(posedge clk_sys) disable iff (rst)
        (has_local_freeze && $past(has_local_freeze) && $stable(st.sync1))
        |=> !freeze_event)
        else $error("freeze event without edge");

    a_pulse_rise: assert property ( // [RL13]
        @(posedge clk_sys) disable iff (rst)
        (!has_local_freeze && $past(has_local_freeze) == 1'b0
         && !st.frz_pol && $rose(drive_freeze_pulse)) |=> freeze_event)
        else $error("rising drive pulse missed");

    a_pulse_fall: assert property ( // [RL13]
        @(posedge clk_sys) disable iff (rst)
        (!has_local_freeze && $past(has_local_freeze) == 1'b0
         && st.frz_pol && $fell(drive_freeze_pulse)) |=> freeze_event)
        else $error("falling drive pulse missed");

    a_net_net_reconfig_seen: assert property ( // [RL3]
        @(posedge clk_sys) disable iff (rst)
        (net_reconfig_seen && !self_forced_reconfig && !net_init_fail)
        |=> st.net_health == NET_RECONFIG)
        else $error("reconfig not reported");

    // Rate figure is never one of the negative codes
    a_net_rate: assert property ( // [RL1]
        @(posedge clk_sys) disable iff (rst)
        (ring_active && !net_reconfig_seen && !self_forced_reconfig
         && !net_init_fail && st.sec_cnt == 32'(SECOND_LEN - 1))
        |=> st.net_health <= NET_MSG_MAX)
        else $error("rate figure out of range");

    a_net_nodata: assert property ( // [RL2]
        @(posedge clk_sys) disable iff (rst)
        (ring_active && !net_reconfig_seen && !self_forced_reconfig
         && !net_init_fail && st.sec_cnt == 32'(SECOND_LEN - 1)
         && st.msg_cnt == 16'h0 && !net_msg_rx)
        |=> st.net_health == NET_NO_DATA)
        else $error("idle ring not reported as zero");
endmodule
`default_nettype wire

// File: dosc_pkg.sv
// Package for the drive option status and control register bank
`default_nettype none
package dosc_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_NET_HEALTH   = 4'h0;
    localparam logic [3:0] ADDR_DL_LOCKOUT   = 4'h1;
    localparam logic [3:0] ADDR_PROF_TRIP    = 4'h2;
    localparam logic [3:0] ADDR_SYNC_STATUS  = 4'h3;
    localparam logic [3:0] ADDR_SEQ_CTRL     = 4'h4;
    localparam logic [3:0] ADDR_FRZ_PASS     = 4'h5;
    localparam logic [3:0] ADDR_FRZ_POL      = 4'h6;
    localparam logic [3:0] ADDR_TASK_PRIO    = 4'h7;
    localparam logic [3:0] ADDR_IRQ_STATUS   = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK     = 4'h9;
    localparam logic [3:0] ADDR_TRIP_CODE    = 4'ha;

    // Network health codes
    localparam logic [15:0] NET_NO_DATA      = 16'h0000;
    localparam logic [15:0] NET_RECONFIG     = 16'hffff;
    localparam logic [15:0] NET_INIT_ERR     = 16'hfffe;
    localparam logic [15:0] NET_SELF_NET_RECONFIG_SEEN   = 16'hfffd;
    localparam logic [15:0] NET_MSG_MAX      = 16'h7fff;

    // Sync status codes
    localparam logic [1:0] SYNC_NONE         = 2'h0;
    localparam logic [1:0] SYNC_MASTER       = 2'h1;
    localparam logic [1:0] SYNC_MASTER_BAD   = 2'h3;

    // Sequence control codes
    localparam logic [1:0] SEQ_RUN           = 2'h0;
    localparam logic [1:0] SEQ_STOP          = 2'h1;
    localparam logic [1:0] SEQ_PAUSE         = 2'h2;
    localparam logic [1:0] SEQ_STEP          = 2'h3;

    // Trip codes
    localparam logic [7:0] TRIP_DOWNLOAD     = 8'h46;
    localparam logic [7:0] TRIP_PROFILE      = 8'h51;

    // Interrupt status bit positions
    localparam int IRQ_FREEZE                = 0;
    localparam int IRQ_TRIP                  = 1;
    localparam int IRQ_DL_REJECT             = 2;
    localparam int IRQ_RECONFIG              = 3;
    localparam int IRQ_BITS                  = 4;

    // One second at 100 MHz, rate window for the message count
    localparam longint CLK_HZ                = 100000000;
    localparam longint SECOND_S              = 1;
    localparam longint SECOND_CYCLES         = SECOND_S * CLK_HZ;
endpackage
`default_nettype wire

// File: dosc_host_model.sv
// Host side model: paced source of network messages
`default_nettype none
module dosc_host_model
    import dosc_pkg::*;
#(
    parameter int GAP = 4
) (
    input  wire logic clk_sys,
    input  wire logic talk,
    output var logic  net_msg_rx = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Fixed pacing, so every full rate window holds the same count
    always @(posedge clk_sys) begin
        cnt <= (cnt + 1) % GAP;
        net_msg_rx <= talk && (cnt == 0);
    end
endmodule
`default_nettype wire

// File: drive_option_status_control_bench.sv
// Bench for the option status and control register bank
`default_nettype none
module drive_option_status_control_bench;
    import dosc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LEN = 20;
    localparam int GAP = 4;
    logic        clk_sys = 1'h0, rst = 1'h1, talk = 1'h0;
    logic        reg_wr = 1'h0, reg_rd = 1'h0, irq;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [1:0]  kick = 2'h0, seq_mode;
    logic [7:0]  trip_code, task_prio;
    logic        ring_active = 1'h0, net_reconfig_seen = 1'h0;
    logic        net_init_fail = 1'h0, self_forced_reconfig = 1'h0;
    logic        drive_enabled = 1'h0, global_trip_en = 1'h0;
    logic        sync_master_req = 1'h0, other_is_master = 1'h0;
    logic        sync_freq_ok = 1'h0, has_local_freeze = 1'h1;
    logic        local_freeze_input = 1'h0, drive_freeze_pulse = 1'h0;
    logic        net_msg_rx, download_reject, trip_req;
    logic        freeze_line, freeze_event;
    int          failures = 0, tests_run = 0;
    int          n_rej = 0, n_trip = 0, n_frz = 0;
    always #5 clk_sys = ~clk_sys;
    // Pulse outputs are counted, so checks need not hit the exact cycle
    always @(posedge clk_sys) begin
        n_rej <= n_rej + int'(download_reject);
        n_trip <= n_trip + int'(trip_req);
        n_frz <= n_frz + int'(freeze_event);
    end
    dosc_regs #(.SECOND_LEN(LEN)) u_dosc_regs (
        .clk_sys                 (clk_sys),
        .rst                     (rst),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_rdata               (reg_rdata),
        .ring_active             (ring_active),
        .net_msg_rx              (net_msg_rx),
        .net_reconfig_seen       (net_reconfig_seen),
        .net_init_fail           (net_init_fail),
        .self_forced_reconfig    (self_forced_reconfig),
        .drive_enabled           (drive_enabled),
        .download_req            (kick[0]),
        .global_trip_en          (global_trip_en),
        .motion_profile_core_err (kick[1]),
        .sync_master_req         (sync_master_req),
        .other_is_master         (other_is_master),
        .sync_freq_ok            (sync_freq_ok),
        .has_local_freeze        (has_local_freeze),
        .local_freeze_input      (local_freeze_input),
        .drive_freeze_pulse      (drive_freeze_pulse),
        .download_reject         (download_reject),
        .trip_req                (trip_req),
        .trip_code               (trip_code),
        .freeze_line             (freeze_line),
        .freeze_event            (freeze_event),
        .seq_mode                (seq_mode),
        .task_prio               (task_prio),
        .irq                     (irq)
    );
    dosc_host_model #(.GAP(GAP)) u_dosc_host_model (.clk_sys(clk_sys),
        .talk(talk), .net_msg_rx(net_msg_rx));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        tk(1);
        reg_rd <= 1'h0;
        chk(reg_rdata, exp);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        kick[k] <= 1'h1;
        @(posedge clk_sys);
        kick[k] <= 1'h0;
        tk(4);
    endtask
    task automatic t_regs;
        for (int a = 0; a < 11; a++)
            rd(4'(a), 16'h0000);
        rd(4'hf, 16'h0000);
        wr(ADDR_TRIP_CODE, 16'h00ff);
        rd(ADDR_TRIP_CODE, 16'h0000);
        wr(ADDR_TASK_PRIO, 16'h005a);
        chk(16'(task_prio), 16'h005a);
        wr(ADDR_TASK_PRIO, 16'h005b);
        rd(ADDR_TASK_PRIO, 16'h005b);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SEQ_CTRL, 16'(i));
            chk(16'(seq_mode), 16'(i));
        end
    endtask
    task automatic t_net;
        ring_active <= 1'h1;
        talk <= 1'h1;
        tk(3 * LEN + 10);
        rd(ADDR_NET_HEALTH, 16'(LEN / GAP));
        talk <= 1'h0;
        tk(2 * LEN + 10);
        rd(ADDR_NET_HEALTH, NET_NO_DATA);
        net_reconfig_seen <= 1'h1;
        tk(2);
        chk(16'(irq), 16'h0000);
        rd(ADDR_NET_HEALTH, NET_RECONFIG);
        self_forced_reconfig <= 1'h1;
        tk(2);
        rd(ADDR_NET_HEALTH, NET_SELF_NET_RECONFIG_SEEN);
        net_init_fail <= 1'h1;
        tk(2);
        rd(ADDR_NET_HEALTH, NET_INIT_ERR);
        wr(ADDR_IRQ_MASK, 16'h000f);
        chk(16'(irq), 16'h0001);
        rd(ADDR_IRQ_STATUS, 16'(1 << IRQ_RECONFIG));
        chk(16'(irq), 16'h0000);
        wr(ADDR_IRQ_MASK, 16'h0000);
    endtask
    task automatic t_trip;
        wr(ADDR_DL_LOCKOUT, 16'h0001);
        drive_enabled <= 1'h1;
        global_trip_en <= 1'h1;
        pulse(0);
        chk(16'(n_rej), 16'h0001);
        rd(ADDR_TRIP_CODE, 16'(TRIP_DOWNLOAD));
        global_trip_en <= 1'h0;
        pulse(0);
        chk(16'(n_trip), 16'h0001);
        drive_enabled <= 1'h0;
        pulse(0);
        chk(16'(n_rej), 16'h0002);
        pulse(1);
        chk(16'(trip_code), 16'(TRIP_PROFILE));
        wr(ADDR_PROF_TRIP, 16'h0001);
        pulse(1);
        chk(16'(n_trip), 16'h0002);
    endtask
    task automatic t_sync;
        logic [15:0] e;
        for (int i = 0; i < 8; i++) begin
            {sync_master_req, other_is_master, sync_freq_ok} <= 3'(i);
            e = (!i[2] || i[1]) ? 16'h0000 : (i[0] ? 16'h0001 : 16'h0003);
            tk(2);
            rd(ADDR_SYNC_STATUS, e);
        end
    endtask
    task automatic t_frz;
        int n;
        wr(ADDR_FRZ_PASS, 16'h0001);
        n = n_frz;
        local_freeze_input <= 1'h1;
        tk(6);
        chk(16'(freeze_line), 16'h0001);
        local_freeze_input <= 1'h0;
        tk(6);
        chk(16'(n_frz - n), 16'h0001);
        wr(ADDR_FRZ_POL, 16'h0001);
        n = n_frz;
        local_freeze_input <= 1'h1;
        tk(6);
        local_freeze_input <= 1'h0;
        tk(6);
        chk(16'(n_frz - n), 16'h0001);
        has_local_freeze <= 1'h0;
        drive_freeze_pulse <= 1'h1;
        tk(4);
        n = n_frz;
        drive_freeze_pulse <= 1'h0;
        tk(4);
        chk(16'(n_frz - n), 16'h0001);
    endtask
    task automatic end_sim;
        if (failures == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        t_regs();
        t_net();
        t_trip();
        t_sync();
        t_frz();
        end_sim();
    end
    // Tests need well under a thousand cycles; allow a wide margin
    initial begin
        #30000;
        failures++;
        end_sim();
    end
endmodule
`default_nettype wire
